// ---- hw/adapter_pkg.sv ----
package adapter_pkg;

    // ************************************************************
    // Register map, byte offsets within the adapter window
    // ************************************************************
    localparam logic [10:0] OFFS_CONFIG_FAULTS = 11'h000;
    localparam logic [10:0] OFFS_MAINT_STATUS  = 11'h004;
    localparam logic [10:0] OFFS_MAINT_ALIAS   = 11'h010;

    // ************************************************************
    // Base address from the transfer request number
    // ************************************************************
    localparam logic [27:0] BUS_BASE_START   = 28'h8000000;
    localparam logic [27:0] BUS_BASE_STRIDE  = 28'h0000800;
    localparam logic [29:0] PHYS_BASE_START  = 30'h20000000;
    localparam logic [29:0] PHYS_BASE_STRIDE = 30'h00002000;
    localparam int          WINDOW_BITS      = 11;
    localparam logic [3:0]  DEFAULT_TR       = 4'hE;

    // ************************************************************
    // Configuration register field positions
    // ************************************************************
    localparam int BIT_PARITY_FAULT   = 31;
    localparam int BIT_WRSEQ_FAULT    = 30;
    localparam int BIT_UNEXP_RD_FAULT = 29;
    localparam int BIT_MULTI_TX_FAULT = 27;
    localparam int BIT_OWN_FAULT      = 26;
    localparam int BIT_POWER_DOWN     = 23;
    localparam int BIT_POWER_UP       = 22;
    localparam int MAINT_WIDTH        = 16;

    // ************************************************************
    // Reset values and strap decode constants
    // ************************************************************
    localparam logic [15:0] MAINT_RESET       = 16'h0000;
    localparam logic [10:0] BOOT_ZERO_CODE_S  = 11'h5DC;
    localparam logic [10:0] BOOT_STEP_S       = 11'h064;
    localparam logic [2:0]  IRQ_LEVEL_BASE    = 3'h4;

    // ************************************************************
    // Access widths on the backplane request
    // ************************************************************
    typedef enum logic [1:0] {
        WIDTH_BYTE  = 2'h0,
        WIDTH_WORD  = 2'h1,
        WIDTH_LONG  = 2'h2,
        WIDTH_OTHER = 2'h3
    } access_width_t;

endpackage

// ---- hw/backplane_adapter_config_faults.sv ----
`timescale 1ns/1ps
// How it works
// RQ1 - Interrupt level is four plus twice high strap plus low strap.
// RQ2 - Panic strap fitted disables panic mode; open enables it.
// RQ3 - Boot timer code zero gives 1500 s, else (code-1)*100 s.
// RQ4 - Arbitration strap fitted suppresses normal link arbitration.
// RQ5 - Header strap fitted selects extended packet headers and trailers.
// RQ6 - Delta-time strap fitted selects long arbitration delta time.
// RQ7 - Ack-timeout strap fitted selects long acknowledgement timeout.
// RQ8 - Registers decode at bus base 0x8000000 plus n times 0x800.
// RQ9 - Default transfer request number is fourteen, base 0x8007000.
// RQ10 - Config writes longword only, reads any width; else error. Code also errors WIDTH_OTHER reads.
// RQ11 - Maintenance register answers at byte offsets 4 and 0x10.
// RQ12 - Bit 31 sets on backplane parity error.
// RQ13 - Bit 30 sets when masked write lacks its next data cycle.
// RQ14 - Bit 29 sets when read data arrives with no read outstanding.
// RQ15 - Bit 27 sets when driven and received sender ids differ.
// RQ16 - Bit 26 sets while this device asserts the fault line.
// RQ17 - Bit 23 sets on supply-low when uninitialised, else microcode.
// RQ18 - Power-down clears on write one or when power-up sets.
// RQ19 - Bit 22 sets on supply-low negation; clears on write or pd.
// RQ20 - Bits 28, 25 and 24 read zero and ignore writes.
module backplane_adapter_config_faults
    import adapter_pkg::*;
#(
    parameter logic [3:0] TR_NUMBER    = DEFAULT_TR,
    // Adapter code value is arbitrary.
    parameter logic [7:0] ADAPTER_CODE = 8'h5A
) (
    // Clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rstn,
    // Straps, fitted reads as 1
    input  wire logic        i_irq_level_low_strap,
    input  wire logic        i_irq_level_high_strap,
    input  wire logic        i_panic_strap,
    input  wire logic        i_boot_timer_strap_3,
    input  wire logic        i_boot_timer_strap_2,
    input  wire logic        i_boot_timer_strap_1,
    input  wire logic        i_boot_timer_strap_0,
    input  wire logic        i_arbitration_disable_strap,
    input  wire logic        i_long_header_strap,
    input  wire logic        i_delta_time_strap,
    input  wire logic        i_ack_timeout_strap,
    // Supply monitor pin
    input  wire logic        i_ac_supply_low,
    // Register access from the backplane
    input  wire logic        i_req,
    input  wire logic        i_write,
    input  wire logic [27:0] i_addr,
    input  wire logic [1:0]  i_width,
    input  wire logic [31:0] i_wdata,
    output logic             o_ack,
    output logic             o_err,
    output logic [31:0]      o_rdata,
    // Fault events from the bus interface logic
    input  wire logic        i_parity_error,
    input  wire logic        i_masked_write_cmd,
    input  wire logic        i_write_data_cycle,
    input  wire logic        i_read_cmd_issued,
    input  wire logic        i_read_data_arrival,
    input  wire logic        i_tx_driving,
    input  wire logic [3:0]  i_tx_id_driven,
    input  wire logic [3:0]  i_tx_id_received,
    input  wire logic        i_own_fault_assert,
    // Port state from microcode
    input  wire logic        i_port_initialized,
    input  wire logic        i_ucode_set_power_down,
    // Configuration derived from straps and registers
    output logic [2:0]       o_interrupt_request_level,
    output logic             o_panic_enable,
    output logic [10:0]      o_boot_timer_seconds,
    output logic             o_arbitration_enable,
    output logic             o_long_header,
    output logic             o_long_delta_time,
    output logic             o_long_ack_timeout,
    output logic [15:0]      o_maint_control
);

    // ************************************************************
    // Pin synchronisation
    // ************************************************************
    logic [11:0] pins_sync;
    logic        hi_s;
    logic        lo_s;
    logic        panic_s;
    logic [3:0]  boot_s;
    logic        arb_s;
    logic        hdr_s;
    logic        delta_s;
    logic        ackto_s;
    logic        ac_supply_low_s;

    pin_sync #(.WIDTH(12)) u_sync (
        .i_clock (i_clock),
        .i_rstn  (i_rstn),
        .i_async ({i_irq_level_high_strap, i_irq_level_low_strap,
                   i_panic_strap, i_boot_timer_strap_3,
                   i_boot_timer_strap_2, i_boot_timer_strap_1,
                   i_boot_timer_strap_0, i_arbitration_disable_strap,
                   i_long_header_strap, i_delta_time_strap,
                   i_ack_timeout_strap, i_ac_supply_low}),
        .o_sync  (pins_sync)
    );

    assign {hi_s, lo_s, panic_s, boot_s, arb_s, hdr_s, delta_s, ackto_s,
            ac_supply_low_s} = pins_sync;

    // ************************************************************
    // Strap decode
    // ************************************************************
    function automatic logic [10:0] boot_seconds(input logic [3:0] code);
        logic [10:0] step;
        step = 11'({7'h00, code} - 11'h001);
        if (code == 4'h0) begin
            boot_seconds = BOOT_ZERO_CODE_S;
        end else begin
            boot_seconds = 11'(step * BOOT_STEP_S);
        end
    endfunction

    // Straps are outputs of synchronisers, so these are registered.
    assign o_interrupt_request_level = IRQ_LEVEL_BASE
                                     | {1'b0, hi_s, lo_s};  // RQ1
    assign o_panic_enable       = ~panic_s;                  // RQ2
    assign o_boot_timer_seconds = boot_seconds(boot_s);      // RQ3
    assign o_arbitration_enable = ~arb_s;                    // RQ4
    assign o_long_header        = hdr_s;                     // RQ5
    assign o_long_delta_time    = delta_s;                   // RQ6
    assign o_long_ack_timeout   = ackto_s;                   // RQ7

    // ************************************************************
    // Address decode and access check
    // ************************************************************
    localparam logic [27:0] BASE_ADDR =
        28'(BUS_BASE_START + 28'(TR_NUMBER) * BUS_BASE_STRIDE); // RQ8 RQ9

    logic [10:0] offs;
    logic        hit;
    logic        sel_cfg;
    logic        sel_maint;
    logic        width_ok;
    logic        good;
    logic        bad;
    logic        cfg_wr;
    logic        maint_wr;

    assign offs      = {i_addr[10:2], 2'b00};
    assign hit       = i_req
                     & (i_addr[27:WINDOW_BITS] == BASE_ADDR[27:WINDOW_BITS]);
    assign sel_cfg   = offs == OFFS_CONFIG_FAULTS;
    assign sel_maint = (offs == OFFS_MAINT_STATUS)
                     | (offs == OFFS_MAINT_ALIAS);           // RQ11
    assign width_ok  = i_write ? (i_width == WIDTH_LONG)
                               : (i_width != WIDTH_OTHER);   // RQ10
    assign good      = hit & width_ok & (sel_cfg | sel_maint);
    assign bad       = hit & ~good;                          // RQ10
    assign cfg_wr    = good & i_write & sel_cfg;
    assign maint_wr  = good & i_write & sel_maint;

    // ************************************************************
    // Fault flags, set wins over write-one-to-clear
    // ************************************************************
    logic par_ff;
    logic wsq_ff;
    logic urd_ff;
    logic mxt_ff;
    logic own_ff;
    logic pd_ff;
    logic pu_ff;
    logic wmask_pend_ff;
    logic rd_out_ff;
    logic ac_supply_low_prev_ff;

    logic set_par;
    logic set_wsq;
    logic set_urd;
    logic set_mxt;
    logic set_own;
    logic ac_supply_low_rise;
    logic ac_supply_low_fall;
    logic set_pd;
    logic set_pu;
    logic [31:0] clr;

    assign clr       = cfg_wr ? i_wdata : 32'h0000_0000;
    assign set_par   = i_parity_error;                       // RQ12
    assign set_wsq   = wmask_pend_ff & ~i_write_data_cycle;  // RQ13
    assign set_urd   = i_read_data_arrival & ~rd_out_ff;     // RQ14
    assign set_mxt   = i_tx_driving
                     & (i_tx_id_driven != i_tx_id_received); // RQ15
    assign set_own   = i_own_fault_assert;                   // RQ16
    assign ac_supply_low_rise = ac_supply_low_s & ~ac_supply_low_prev_ff;
    assign ac_supply_low_fall = ~ac_supply_low_s & ac_supply_low_prev_ff;
    assign set_pd    = (ac_supply_low_rise & ~i_port_initialized)
                     | (i_ucode_set_power_down & i_port_initialized); // RQ17
    assign set_pu    = ac_supply_low_fall;                            // RQ19

    logic nxt_pd;
    logic nxt_pu;

    // A power-up event overrides a simultaneous power-down event.
    assign nxt_pd = ~set_pu
                  & (set_pd | (pd_ff & ~clr[BIT_POWER_DOWN])); // RQ18
    assign nxt_pu = set_pu
                  | (pu_ff & ~clr[BIT_POWER_UP] & ~set_pd);  // RQ19

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            par_ff        <= 1'b0;
            wsq_ff        <= 1'b0;
            urd_ff        <= 1'b0;
            mxt_ff        <= 1'b0;
            own_ff        <= 1'b0;
            pd_ff         <= 1'b0;
            pu_ff         <= 1'b0;
            wmask_pend_ff <= 1'b0;
            rd_out_ff     <= 1'b0;
            ac_supply_low_prev_ff  <= 1'b0;
        end else begin
            par_ff <= set_par | (par_ff & ~clr[BIT_PARITY_FAULT]);   // RQ12
            wsq_ff <= set_wsq | (wsq_ff & ~clr[BIT_WRSEQ_FAULT]);    // RQ13
            urd_ff <= set_urd | (urd_ff & ~clr[BIT_UNEXP_RD_FAULT]); // RQ14
            mxt_ff <= set_mxt | (mxt_ff & ~clr[BIT_MULTI_TX_FAULT]); // RQ15
            own_ff <= set_own | (own_ff & ~clr[BIT_OWN_FAULT]);      // RQ16
            pd_ff         <= nxt_pd;
            pu_ff         <= nxt_pu;
            wmask_pend_ff <= i_masked_write_cmd;
            rd_out_ff     <= i_read_cmd_issued
                           | (rd_out_ff & ~i_read_data_arrival);
            ac_supply_low_prev_ff  <= ac_supply_low_s;
        end
    end

    // ************************************************************
    // Register read-back and answer
    // ************************************************************
    logic [15:0] maint_ff;
    logic [31:0] cfg_value;
    logic [31:0] read_value;

    // Reserved bits are constant zero, so writes cannot reach them.
    assign cfg_value = {par_ff, wsq_ff, urd_ff, 1'b0, mxt_ff, own_ff,
                        2'b00, pd_ff, pu_ff, 14'h0000,
                        ADAPTER_CODE};                        // RQ20
    assign read_value = sel_cfg ? cfg_value : {16'h0000, maint_ff};

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            maint_ff <= MAINT_RESET;
            o_ack    <= 1'b0;
            o_err    <= 1'b0;
            o_rdata  <= 32'h0000_0000;
        end else begin
            if (maint_wr) begin
                maint_ff <= i_wdata[MAINT_WIDTH-1:0];        // RQ11
            end
            o_ack   <= good;
            o_err   <= bad;                                  // RQ10
            o_rdata <= (good & ~i_write) ? read_value : 32'h0000_0000;
        end
    end

    assign o_maint_control = maint_ff;

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence s_masked_no_data;
        i_masked_write_cmd ##1 !i_write_data_cycle;
    endsequence

    sequence s_alias_read;
        i_req && !i_write && i_width == WIDTH_LONG
            && i_addr == 28'(BASE_ADDR + 28'(OFFS_MAINT_ALIAS));
    endsequence

    property p_irq_level;
        @(posedge i_clock) disable iff (!i_rstn)
        (hi_s && !lo_s) |-> o_interrupt_request_level == 3'h6;
    endproperty
    a_irq_level: assert property (p_irq_level) // RQ1
        else $error("interrupt level wrong for strap setting");

    property p_boot_timer;
        @(posedge i_clock) disable iff (!i_rstn)
        (boot_s == 4'h0 |-> o_boot_timer_seconds == 11'd1500)
        and (boot_s == 4'h1 |-> o_boot_timer_seconds == 11'd0);
    endproperty
    a_boot_timer: assert property (p_boot_timer) // RQ3
        else $error("boot timer decode wrong");

    property p_wrseq;
        @(posedge i_clock) disable iff (!i_rstn)
        s_masked_no_data |=> wsq_ff;
    endproperty
    a_wrseq: assert property (p_wrseq) // RQ13
        else $error("write sequence fault not set");

    property p_unexp_read;
        @(posedge i_clock) disable iff (!i_rstn)
        (i_read_data_arrival && !rd_out_ff) |=> urd_ff;
    endproperty
    a_unexp_read: assert property (p_unexp_read) // RQ14
        else $error("unexpected read fault not set");

    property p_multi_tx;
        @(posedge i_clock) disable iff (!i_rstn)
        (i_tx_driving && i_tx_id_driven != i_tx_id_received) |=> mxt_ff;
    endproperty
    a_multi_tx: assert property (p_multi_tx) // RQ15
        else $error("multiple sender fault not set");

    property p_power_down;
        @(posedge i_clock) disable iff (!i_rstn)
        (ac_supply_low_rise && !i_port_initialized) |=> pd_ff && !pu_ff;
    endproperty
    a_power_down: assert property (p_power_down) // RQ17
        else $error("power down flag not set on supply low");

    property p_power_up;
        @(posedge i_clock) disable iff (!i_rstn)
        $fell(ac_supply_low_s) |-> ##1 (pu_ff && !pd_ff);
    endproperty
    a_power_up: assert property (p_power_up) // RQ19
        else $error("power up flag wrong on supply return");

    property p_width;
        @(posedge i_clock) disable iff (!i_rstn)
        (hit && i_write && i_width != WIDTH_LONG) |=> o_err && !o_ack;
    endproperty
    a_width: assert property (p_width) // RQ10
        else $error("short write not refused");

    property p_alias;
        @(posedge i_clock) disable iff (!i_rstn)
        s_alias_read |=> o_ack && o_rdata == {16'h0000, maint_ff};
    endproperty
    a_alias: assert property (p_alias) // RQ11
        else $error("maintenance alias read wrong");

    property p_reserved;
        @(posedge i_clock) disable iff (!i_rstn)
        o_ack |-> (o_rdata[28] == 1'b0 && o_rdata[25:24] == 2'b00);
    endproperty
    a_reserved: assert property (p_reserved) // RQ20
        else $error("reserved bits read nonzero");

endmodule

// ---- hw/pin_sync.sv ----
`timescale 1ns/1ps
module pin_sync
    import adapter_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             i_clock,
    input  wire logic             i_rstn,
    // Asynchronous pins and their synchronised copies
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] stage1_ff;
    logic [WIDTH-1:0] stage2_ff;

    // The first stage feeds only the second stage.
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            stage1_ff <= '0;
            stage2_ff <= '0;
        end else begin
            stage1_ff <= i_async;
            stage2_ff <= stage1_ff;
        end
    end

    assign o_sync = stage2_ff;

endmodule

// ---- testbench/backplane_adapter_config_faults_tb.sv ----
`timescale 1ns/1ps
module backplane_adapter_config_faults_tb
    import adapter_pkg::*;
();
    localparam logic [27:0] BASE = 28'h8000000 + 28'hE * 28'h800;
    // Adapter code value is arbitrary.
    localparam logic [7:0]  CODE = 8'h3C;
    localparam logic [31:0] IDLE = {24'h000000, CODE};

    logic        clock;
    logic        rstn;
    logic        irq_lo, irq_hi, panic, arb, hdr, delta, acktmo;
    logic [3:0]  boot;
    logic        ac_low, port_init, ucode_pd;
    logic        req, wr_en, ack, err, ans_ack, ans_err;
    logic [27:0] addr;
    logic [1:0]  width;
    logic [31:0] wdata, rdata, ans_data;
    logic [6:0]  ev;
    logic [3:0]  id_rx, id_tx;
    logic [2:0]  irq_level;
    logic        panic_en, arb_en, long_hdr, long_delta, long_ack;
    logic [10:0] boot_s;
    logic [15:0] maint;
    int          miscompares = 0;
    int          n_compared = 0;

    backplane_adapter_config_faults #(.ADAPTER_CODE(CODE))
    i_backplane_adapter_config_faults (
        .i_clock(clock), .i_rstn(rstn),
        .i_irq_level_low_strap(irq_lo), .i_irq_level_high_strap(irq_hi),
        .i_panic_strap(panic), .i_boot_timer_strap_3(boot[3]),
        .i_boot_timer_strap_2(boot[2]), .i_boot_timer_strap_1(boot[1]),
        .i_boot_timer_strap_0(boot[0]), .i_arbitration_disable_strap(arb),
        .i_long_header_strap(hdr), .i_delta_time_strap(delta),
        .i_ack_timeout_strap(acktmo), .i_ac_supply_low(ac_low),
        .i_req(req), .i_write(wr_en), .i_addr(addr), .i_width(width),
        .i_wdata(wdata), .o_ack(ack), .o_err(err), .o_rdata(rdata),
        .i_parity_error(ev[0]), .i_masked_write_cmd(ev[1]),
        .i_write_data_cycle(ev[2]), .i_read_cmd_issued(ev[3]),
        .i_read_data_arrival(ev[4]), .i_tx_driving(ev[5]),
        .i_tx_id_driven(id_tx), .i_tx_id_received(id_rx),
        .i_own_fault_assert(ev[6]), .i_port_initialized(port_init),
        .i_ucode_set_power_down(ucode_pd),
        .o_interrupt_request_level(irq_level), .o_panic_enable(panic_en),
        .o_boot_timer_seconds(boot_s), .o_arbitration_enable(arb_en),
        .o_long_header(long_hdr), .o_long_delta_time(long_delta),
        .o_long_ack_timeout(long_ack), .o_maint_control(maint));

    host_bus_model i_host_bus_model (
        .i_clock(clock), .o_req(req), .o_write(wr_en), .o_addr(addr),
        .o_width(width), .o_wdata(wdata), .i_ack(ack), .i_err(err),
        .i_rdata(rdata), .o_events(ev), .o_id_received(id_rx));

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic check(input string name, input logic [31:0] exp,
                         input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            miscompares++;
        end
    endtask

    task automatic xfer(input logic w, input logic [27:0] a,
                        input logic [1:0] wd, input logic [31:0] d,
                        input logic exp_ack, input logic exp_err);
        i_host_bus_model.access(w, a, wd, d, ans_ack, ans_err, ans_data);
        check("ack", {31'h0, exp_ack}, {31'h0, ans_ack});
        check("err", {31'h0, exp_err}, {31'h0, ans_err});
    endtask

    task automatic rd(input logic [10:0] off, input logic [1:0] wd,
                      input logic [31:0] exp);
        xfer(1'b0, BASE + {17'h0, off}, wd, 32'h0, 1'b1, 1'b0);
        check("read data", exp, ans_data);
    endtask

    task automatic wr(input logic [10:0] off, input logic [31:0] d);
        xfer(1'b1, BASE + {17'h0, off}, WIDTH_LONG, d, 1'b1, 1'b0);
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic test_straps();
        logic [10:0] exp_boot;
        for (int i = 0; i < 16; i++) begin
            @(negedge clock);
            {irq_hi, irq_lo} = i[1:0];
            boot = i[3:0];
            {panic, arb, hdr, delta, acktmo} = {i[0], i[1], i[2], i[3], ~i[0]};
            repeat (6) @(negedge clock);
            exp_boot = (i == 0) ? 11'h5DC : 11'(i - 1) * 11'h064;
            check("irq level", {30'h1, i[1:0]}, {29'h0, irq_level});
            check("panic", {31'h0, ~i[0]}, {31'h0, panic_en});
            check("boot", {21'h0, exp_boot}, {21'h0, boot_s});
            check("arb", {31'h0, ~i[1]}, {31'h0, arb_en});
            check("header", {31'h0, i[2]}, {31'h0, long_hdr});
            check("delta", {31'h0, i[3]}, {31'h0, long_delta});
            check("ack tmo", {31'h0, ~i[0]}, {31'h0, long_ack});
        end
    endtask

    task automatic test_decode();
        rd(11'h000, WIDTH_BYTE, IDLE);
        rd(11'h000, WIDTH_WORD, IDLE);
        wr(11'h000, 32'hFFFFFFFF);
        rd(11'h000, WIDTH_LONG, IDLE);
        wr(11'h004, 32'h1234ABCD);
        rd(11'h010, WIDTH_LONG, 32'h0000ABCD);
        rd(11'h004, WIDTH_BYTE, 32'h0000ABCD);
        check("maint", 32'h0000ABCD, {16'h0, maint});
        xfer(1'b1, BASE, WIDTH_WORD, 32'h0, 1'b0, 1'b1);
        xfer(1'b1, BASE + 28'h4, WIDTH_BYTE, 32'h0, 1'b0, 1'b1);
        xfer(1'b0, BASE, WIDTH_OTHER, 32'h0, 1'b0, 1'b1);
        xfer(1'b0, BASE + 28'h8, WIDTH_LONG, 32'h0, 1'b0, 1'b1);
        xfer(1'b0, BASE + 28'h800, WIDTH_LONG, 32'h0, 1'b0, 1'b0);
        xfer(1'b0, BASE - 28'h800, WIDTH_LONG, 32'h0, 1'b0, 1'b0);
        rd(11'h004, WIDTH_LONG, 32'h0000ABCD);
    endtask

    task automatic test_faults();
        logic [6:0]  ev_a [8];
        logic [6:0]  ev_b [8];
        logic [31:0] mask [8];
        ev_a = '{7'h01, 7'h02, 7'h02, 7'h10, 7'h08, 7'h20, 7'h20, 7'h40};
        ev_b = '{7'h00, 7'h00, 7'h04, 7'h00, 7'h10, 7'h00, 7'h00, 7'h00};
        mask = '{32'h80000000, 32'h40000000, 32'h0, 32'h20000000,
                 32'h0, 32'h08000000, 32'h0, 32'h04000000};
        for (int k = 0; k < 8; k++) begin
            id_tx = (k == 6) ? 4'h6 : 4'h9;
            i_host_bus_model.cycle(ev_a[k], (k == 5) ? 4'h6 : id_tx);
            i_host_bus_model.cycle(ev_b[k], 4'h9);
            i_host_bus_model.cycle(7'h00, 4'h0);
            rd(11'h0, WIDTH_LONG, IDLE|mask[k]);
            wr(11'h000, mask[k]);
            rd(11'h000, WIDTH_LONG, IDLE);
        end
    endtask

    task automatic test_power();
        ac_low = 1'b1;
        repeat (6) @(negedge clock);
        rd(11'h000, WIDTH_LONG, IDLE | 32'h00800000);
        ac_low = 1'b0;
        repeat (6) @(negedge clock);
        rd(11'h000, WIDTH_LONG, IDLE | 32'h00400000);
        ac_low = 1'b1;
        repeat (6) @(negedge clock);
        rd(11'h000, WIDTH_LONG, IDLE | 32'h00800000);
        ac_low = 1'b0;
        repeat (6) @(negedge clock);
        wr(11'h000, 32'h00400000);
        rd(11'h000, WIDTH_LONG, IDLE);
        port_init = 1'b1;
        ac_low = 1'b1;
        repeat (6) @(negedge clock);
        rd(11'h000, WIDTH_LONG, IDLE);
        ucode_pd = 1'b1;
        @(negedge clock);
        ucode_pd = 1'b0;
        rd(11'h000, WIDTH_LONG, IDLE | 32'h00800000);
        wr(11'h000, 32'h00800000);
        rd(11'h000, WIDTH_LONG, IDLE);
    endtask

    // ************************************************************
    // Clock, sequence, watchdog and verdict
    // ************************************************************
    task automatic finish_test();
        if (miscompares == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    initial begin
        rstn = 1'b0;
        {irq_lo, irq_hi, panic, arb, hdr, delta, acktmo} = 7'h00;
        boot = 4'h0;
        id_tx = 4'h9;
        {ac_low, port_init, ucode_pd} = 3'h0;
        repeat (6) @(negedge clock);
        rstn = 1'b1;
        test_straps();
        test_decode();
        test_faults();
        test_power();
        finish_test();
    end

    // The whole sequence needs well under a thousand cycles.
    initial begin
        #200000;
        miscompares++;
        finish_test();
    end
endmodule

// ---- testbench/host_bus_model.sv ----
`timescale 1ns/1ps
module host_bus_model
    import adapter_pkg::*;
(
    // Clock
    input  wire logic        i_clock,
    // Register access toward the adapter
    output logic             o_req,
    output logic             o_write,
    output logic [27:0]      o_addr,
    output logic [1:0]       o_width,
    output logic [31:0]      o_wdata,
    input  wire logic        i_ack,
    input  wire logic        i_err,
    input  wire logic [31:0] i_rdata,
    // Bus events: own fault, driving, rd data, rd cmd, wr data, mask, par
    output logic [6:0]       o_events,
    output logic [3:0]       o_id_received
);
    initial begin
        o_req = 1'b0;
        o_write = 1'b0;
        o_addr = 28'h0000000;
        o_width = 2'h0;
        o_wdata = 32'h00000000;
        o_events = 7'h00;
        o_id_received = 4'h0;
    end

    // ************************************************************
    // One register access, request held for the taking edge
    // ************************************************************
    task automatic access(input logic wr, input logic [27:0] addr,
                          input logic [1:0] width, input logic [31:0] wdata,
                          output logic ack, output logic err,
                          output logic [31:0] rdata);
        @(negedge i_clock);
        o_req = 1'b1;
        o_write = wr;
        o_addr = addr;
        o_width = width;
        o_wdata = wdata;
        @(posedge i_clock);
        @(negedge i_clock);
        ack = i_ack;
        err = i_err;
        rdata = i_rdata;
        // Released lines show the inverse so a stale value never matches.
        o_req = 1'b0;
        o_write = ~wr;
        o_addr = ~addr;
        o_width = ~width;
        o_wdata = ~wdata;
    endtask

    // ************************************************************
    // One bus cycle of events; ids are only meaningful while driving
    // ************************************************************
    task automatic cycle(input logic [6:0] ev, input logic [3:0] id_rx);
        @(negedge i_clock);
        o_events = ev;
        o_id_received = ev[5] ? id_rx : ~o_id_received;
    endtask
endmodule
